/* File: simple_serial_bus_8bit_addr_serial_register_write_tb.sv */
// Bench: host and device ends joined, plus a second device fed by a host driver in here.
// Assumes a 40 MHz sys_clk; the second link is driven directly, so it can break the frame.
module simple_serial_bus_8bit_addr_serial_register_write_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int H_HS = 500 / 25;
    localparam int H_LS = 15000 / 25;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0, high_speed = 1'b1, irq_req = 1'b0;
    logic [7:0] req_addr = 8'h00, req_data = 8'h00;
    logic req_ready, wr_done, ack_fail, irq_seen, wr_valid, frame_err;
    logic [7:0] wr_addr, wr_data, wr_addr_b, wr_data_b;
    logic wr_valid_b, frame_err_b, got_wr_b, got_err_b;
    logic [15:0] exp_q[$];
    int failures = 0, checked = 0;
    ssb_link_if lnk();
    ssb_link_if lnk_b();

    ssb_host i_ssb_host (.sys_clk(sys_clk), .srst(srst), .req_valid(req_valid),
        .req_addr(req_addr), .req_data(req_data), .high_speed(high_speed),
        .req_ready(req_ready), .wr_done(wr_done), .ack_fail(ack_fail),
        .irq_seen(irq_seen), .bus(lnk.host));
    ssb_dev i_ssb_dev (.sys_clk(sys_clk), .srst(srst), .irq_req(irq_req), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .frame_err(frame_err), .bus(lnk.device));
    ssb_dev i_ssb_dev_b (.sys_clk(sys_clk), .srst(srst), .irq_req(1'b0), .wr_valid(wr_valid_b),
        .wr_addr(wr_addr_b), .wr_data(wr_data_b), .frame_err(frame_err_b), .bus(lnk_b.device));
    ssb_link_assertions u_chk (.sys_clk(sys_clk), .srst(srst), .m_sck_o(lnk.m_sck_o),
        .m_sck_oe(lnk.m_sck_oe), .m_apl_o(lnk.m_apl_o), .m_apl_oe(lnk.m_apl_oe),
        .m_sdd_o(lnk.m_sdd_o), .m_sdd_oe(lnk.m_sdd_oe), .s_apl_o(lnk.s_apl_o),
        .s_apl_oe(lnk.s_apl_oe), .s_sdd_o(lnk.s_sdd_o), .s_sdd_oe(lnk.s_sdd_oe),
        .bit_clk(lnk.bit_clk), .addr_phase_irq_line(lnk.addr_phase_irq_line),
        .serial_data_line(lnk.serial_data_line));

    always #12.5 sys_clk = ~sys_clk;

    // Model of the joined device: each good write must match the oldest request
    always @(posedge sys_clk) begin
        if (wr_valid === 1'b1) begin
            cmp("write seen", 1, exp_q.size() > 0);
            if (exp_q.size() > 0) cmp("addr/data", exp_q.pop_front(), {wr_addr, wr_data});
        end
        if (frame_err === 1'b1 || ack_fail === 1'b1) cmp("fault pulse", 0, 1);
        if (wr_valid_b === 1'b1) got_wr_b = 1'b1;
        if (frame_err_b === 1'b1) got_err_b = 1'b1;
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Inputs always move the same small delay after the edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic tally_and_finish();
        $display("COUNTS checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        $display("ERROR timeout %s expected 1 seen 0", what);
        failures++;
        tally_and_finish();
    endtask

    // One write on the joined link, timed from the take edge to the done pulse
    task automatic host_write(input logic [7:0] a, input logic [7:0] d, input logic hs);
        int n;
        n = 0;
        req_addr = a;
        req_data = d;
        high_speed = hs;
        req_valid = 1'b1;
        exp_q.push_back({a, d});
        while (req_ready !== 1'b1) begin
            step(1);
            n++;
            if (n > 50) give_up("req_ready");
        end
        step(1);
        req_valid = 1'b0;
        n = 0;
        while (wr_done !== 1'b1) begin
            step(1);
            n++;
            if (n > 40 * H_LS) give_up("wr_done");
        end
        cmp("frame cycles", 37 * (hs ? H_HS : H_LS), n);
    endtask

    // One frame on the second link; bad names a bit sent with the address line in the wrong phase
    task automatic frame_b(input logic [7:0] a, input logic [7:0] d, input int bad);
        logic ack;
        logic trl;
        got_wr_b = 1'b0;
        got_err_b = 1'b0;
        for (int i = 0; i < 18; i++) begin
            lnk_b.m_apl_oe = (i < 8) ^ (i == bad);
            lnk_b.m_sdd_oe = (i < 8) ? !a[i] : (i < 16) ? !d[i - 8] : 1'b0;
            lnk_b.m_sck_oe = 1'b1;
            step(4);
            lnk_b.m_sck_oe = 1'b0;
            step(4);
            if (i == 16) ack = lnk_b.serial_data_line;
            if (i == 17) trl = lnk_b.serial_data_line;
        end
        lnk_b.m_apl_oe = 1'b0;
        step(4);
        cmp("ack", (bad < 0) ? !d[7] : d[7], ack);
        cmp("trailer", 1, trl);
        cmp("good write", bad < 0, got_wr_b);
        cmp("frame error", bad >= 0, got_err_b);
        if (bad < 0) cmp("addr/data b", {a, d}, {wr_addr_b, wr_data_b});
    endtask

    initial begin
        static logic [15:0] bnd [4] = '{16'h0000, 16'hffff, 16'h0180, 16'h807f};
        void'($urandom(32'h7d17));
        {lnk_b.m_sck_o, lnk_b.m_apl_o, lnk_b.m_sdd_o} = 3'h0;
        {lnk_b.m_sck_oe, lnk_b.m_apl_oe, lnk_b.m_sdd_oe} = 3'h0;
        step(2);
        srst = 1'b0;
        step(3);
        // Boundary bytes give both acknowledge polarities
        foreach (bnd[i]) host_write(bnd[i][15:8], bnd[i][7:0], 1'b1);
        $display("TEST boundary done");
        for (int i = 0; i < 6; i++) host_write(8'($urandom), 8'($urandom), 1'b1);
        $display("TEST random back-to-back done");
        host_write(8'($urandom), 8'($urandom), 1'b0);
        $display("TEST low speed done");
        // Interrupt asked at idle, then cleared by the next frame's first clock fall
        irq_req = 1'b1;
        step(1);
        irq_req = 1'b0;
        step(8);
        cmp("irq seen", 1, irq_seen);
        host_write(8'h3c, 8'hc3, 1'b1);
        step(4);
        cmp("irq cleared", 0, irq_seen);
        cmp("irq line idle", 1, lnk.addr_phase_irq_line);
        $display("TEST interrupt done");
        // Faulty frames on the second link: address line high in address, low in data
        frame_b(8'h5a, 8'h96, -1);
        for (int k = 0; k < 2; k++) begin
            frame_b(8'($urandom), 8'($urandom), k ? 12 : 3);
            step(4);
            cmp("fault irq line", 0, lnk_b.addr_phase_irq_line);
            frame_b(8'($urandom), 8'($urandom), -1);
            cmp("fault irq released", 1, lnk_b.addr_phase_irq_line);
        end
        $display("TEST faulty host done");
        cmp("pending writes", 0, exp_q.size());
        tally_and_finish();
    end
endmodule

/* File: ssb_dev.sv */
// Device end: receives register writes on the serial bus and acknowledges them.
// Assumes the host makes the bit clock; all bus lines are resynchronised to sys_clk.
module ssb_dev (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // User side
    input wire logic irq_req,
    output logic wr_valid,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic frame_err,
    // Bus side
    ssb_link_if.device bus
);

    // ************************************************************
    // Line synchronisers
    // ************************************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic sck_prev;

    // Two flops per line; only sync2 and later are looked at
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sck_prev <= 1'b1;
        end else begin
            sync1 <= {bus.bit_clk, bus.addr_phase_irq_line, bus.serial_data_line};
            sync2 <= sync1;
            sck_prev <= sync2[2];
        end
    end

    logic sck_fall;
    logic sck_rise;
    logic apl_in;
    logic sdd_in;
    assign sck_fall = sck_prev && !sync2[2];
    assign sck_rise = !sck_prev && sync2[2];
    assign apl_in = sync2[1];
    assign sdd_in = sync2[0];

    // ************************************************************
    // Frame receiver
    // ************************************************************
    ssb_pkg::ssb_slv_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [7:0] sh_addr, next_sh_addr;
    logic [7:0] sh_data, next_sh_data;
    logic err, next_err;
    logic irq_pend, next_irq_pend;
    logic apl_low, next_apl_low;
    logic sdd_low, next_sdd_low;
    logic next_wr_valid;
    logic next_frame_err;
    logic [7:0] next_wr_addr;
    logic [7:0] next_wr_data;

    // Next values of the receiver
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh_addr = sh_addr;
        next_sh_data = sh_data;
        next_err = err;
        next_irq_pend = irq_pend || irq_req;
        next_apl_low = apl_low;
        next_sdd_low = sdd_low;
        next_wr_valid = 1'b0;
        next_frame_err = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        unique case (state)
            ssb_pkg::SSB_S_IDLE: begin
                next_apl_low = irq_pend;
                if (sck_fall) begin
                    next_apl_low = 1'b0;
                    next_irq_pend = irq_req;                  // New request wins over clear
                    next_err = 1'b0;
                    next_cnt = 3'h0;
                    next_state = ssb_pkg::SSB_S_ADDR;
                end
            end
            ssb_pkg::SSB_S_ADDR: begin
                if (sck_rise) begin
                    next_sh_addr[cnt] = sdd_in;
                    next_err = err || apl_in;                 // Line must be low here
                    next_cnt = cnt + 3'h1;
                    if (cnt == ssb_pkg::CNT_LAST) begin
                        next_state = ssb_pkg::SSB_S_DATA;
                    end
                end
            end
            ssb_pkg::SSB_S_DATA: begin
                if (sck_rise) begin
                    next_sh_data[cnt] = sdd_in;
                    next_err = err || !apl_in;
                    next_cnt = cnt + 3'h1;
                    if (cnt == ssb_pkg::CNT_LAST) begin
                        next_state = ssb_pkg::SSB_S_ACK;
                    end
                end
            end
            ssb_pkg::SSB_S_ACK: begin
                // A bad frame answers with the wrong level so the host repeats it
                if (sck_fall) begin
                    next_sdd_low = sh_data[7] ^ err;
                    next_state = ssb_pkg::SSB_S_HOLD;
                end
            end
            ssb_pkg::SSB_S_HOLD: begin
                if (sck_fall) begin
                    next_sdd_low = 1'b0;
                    next_state = ssb_pkg::SSB_S_FIN;
                end
            end
            ssb_pkg::SSB_S_FIN: begin
                if (sck_rise) begin
                    next_wr_valid = !err;
                    next_frame_err = err;
                    next_irq_pend = irq_pend || irq_req || err;
                    if (!err) begin
                        next_wr_addr = sh_addr;
                        next_wr_data = sh_data;
                    end
                    next_state = ssb_pkg::SSB_S_IDLE;
                end
            end
            default: begin
                next_state = ssb_pkg::SSB_S_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ssb_pkg::SSB_S_IDLE;
            cnt <= 3'h0;
            sh_addr <= ssb_pkg::BYTE_RST;
            sh_data <= ssb_pkg::BYTE_RST;
            err <= 1'b0;
            irq_pend <= 1'b0;
            apl_low <= 1'b0;
            sdd_low <= 1'b0;
            wr_valid <= 1'b0;
            frame_err <= 1'b0;
            wr_addr <= ssb_pkg::BYTE_RST;
            wr_data <= ssb_pkg::BYTE_RST;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh_addr <= next_sh_addr;
            sh_data <= next_sh_data;
            err <= next_err;
            irq_pend <= next_irq_pend;
            apl_low <= next_apl_low;
            sdd_low <= next_sdd_low;
            wr_valid <= next_wr_valid;
            frame_err <= next_frame_err;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // Open drain: only ever pull low, the pull-up gives the high level
    assign bus.s_apl_o = 1'b0;
    assign bus.s_apl_oe = apl_low;
    assign bus.s_sdd_o = 1'b0;
    assign bus.s_sdd_oe = sdd_low;

endmodule

/* File: ssb_host.sv */
// Host end: bus master that clocks out register writes and checks the acknowledge.
// Assumes requests come from logic on sys_clk; bus inputs are resynchronised here.

// Notes on behaviour
// - Eight address bits, then eight data bits.
// - Address line low, address sent LSB first.
// - Clock low half, then high half, per bit.
// - Address line high after last address bit.
// - Data byte sent LSB first, same clocking.
// - Release data line after last data bit.
// - Device answers inverse of last data bit.
// - Sample answer after clock rise; check inverse.
// - Device releases data line; frame then ends.
// - Failed acknowledge repeats the whole write.
// - First clock fall: device releases address line.
// - Device pulls address line low on failure.
// - Host drives lines only when pulling low.
// - All lines idle high through pull-ups.
// - Low speed: 30 us clock period.
// - LSB first; address line low only addressing.
module ssb_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Request side
    input wire logic req_valid,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic high_speed,
    output logic req_ready,
    output logic wr_done,
    output logic ack_fail,
    output logic irq_seen,
    // Bus side
    ssb_link_if.host bus
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] sync1;
    logic [1:0] sync2;

    // Two flops on each line read back from the bus
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1 <= 2'h3;
            sync2 <= 2'h3;
        end else begin
            sync1 <= {bus.addr_phase_irq_line, bus.serial_data_line};
            sync2 <= sync1;
        end
    end

    logic apl_in;
    logic sdd_in;
    assign apl_in = sync2[1];
    assign sdd_in = sync2[0];

    // ************************************************************
    // Half-period lengths
    // ************************************************************
    localparam logic [ssb_pkg::HALF_W-1:0] HALF_LS_LAST =
        ssb_pkg::HALF_W'(ssb_pkg::HALF_LS_CYC - 1);
    localparam logic [ssb_pkg::HALF_W-1:0] HALF_HS_LAST =
        ssb_pkg::HALF_W'(ssb_pkg::HALF_HS_CYC - 1);

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    ssb_pkg::ssb_mst_state_t state, next_state;
    logic [ssb_pkg::HALF_W-1:0] cnt, next_cnt;
    logic [ssb_pkg::HALF_W-1:0] half_last;
    logic [4:0] bit_idx, next_bit_idx;
    logic [4:0] nb;
    logic [7:0] addr, next_addr;
    logic [7:0] data, next_data;
    logic speed, next_speed;
    logic ack_ok, next_ack_ok;
    logic sck_low, next_sck_low;
    logic apl_low, next_apl_low;
    logic sdd_low, next_sdd_low;
    logic next_req_ready;
    logic next_wr_done;
    logic next_ack_fail;
    logic next_irq_seen;

    // Both speeds share one counter; the speed is frozen for the whole frame
    assign half_last = speed ? HALF_HS_LAST : HALF_LS_LAST;
    assign nb = bit_idx + 5'h01;

    // Next values of the sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_bit_idx = bit_idx;
        next_addr = addr;
        next_data = data;
        next_speed = speed;
        next_ack_ok = ack_ok;
        next_sck_low = sck_low;
        next_apl_low = apl_low;
        next_sdd_low = sdd_low;
        next_req_ready = 1'b0;
        next_wr_done = 1'b0;
        next_ack_fail = 1'b0;
        next_irq_seen = (state == ssb_pkg::SSB_M_IDLE) && !apl_in;
        unique case (state)
            ssb_pkg::SSB_M_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_addr = req_addr;
                    next_data = req_data;
                    next_speed = high_speed;
                    next_cnt = high_speed ? HALF_HS_LAST : HALF_LS_LAST;
                    next_bit_idx = ssb_pkg::BIT_FIRST;
                    next_apl_low = 1'b1;
                    next_sdd_low = !req_addr[0];
                    next_sck_low = 1'b1;
                    next_state = ssb_pkg::SSB_M_LOW;
                end
            end
            ssb_pkg::SSB_M_LOW: begin
                next_cnt = cnt - 1'b1;
                if (cnt == '0) begin
                    next_sck_low = 1'b0;
                    next_cnt = half_last;
                    next_state = ssb_pkg::SSB_M_HIGH;
                end
            end
            ssb_pkg::SSB_M_HIGH: begin
                next_cnt = cnt - 1'b1;
                if (cnt == '0) begin
                    next_cnt = half_last;
                    if (bit_idx == ssb_pkg::BIT_ACK) begin
                        next_ack_ok = (sdd_in == !data[7]);
                    end
                    if (bit_idx == ssb_pkg::BIT_END) begin
                        next_state = ssb_pkg::SSB_M_GAP;
                    end else begin
                        next_bit_idx = nb;
                        next_sck_low = 1'b1;
                        next_state = ssb_pkg::SSB_M_LOW;
                        if (nb < ssb_pkg::BIT_DATA0) begin
                            next_sdd_low = !addr[nb[2:0]];
                        end else if (nb < ssb_pkg::BIT_ACK) begin
                            next_apl_low = 1'b0;
                            next_sdd_low = !data[nb[2:0]];
                        end else begin
                            next_sdd_low = 1'b0;
                        end
                    end
                end
            end
            ssb_pkg::SSB_M_GAP: begin
                // One idle half-period keeps frames apart
                next_cnt = cnt - 1'b1;
                if (cnt == '0) begin
                    if (ack_ok) begin
                        next_wr_done = 1'b1;
                        next_req_ready = 1'b1;
                        next_state = ssb_pkg::SSB_M_IDLE;
                    end else begin
                        // Same byte pair again from the first address bit
                        next_ack_fail = 1'b1;
                        next_cnt = half_last;
                        next_bit_idx = ssb_pkg::BIT_FIRST;
                        next_apl_low = 1'b1;
                        next_sdd_low = !addr[0];
                        next_sck_low = 1'b1;
                        next_state = ssb_pkg::SSB_M_LOW;
                    end
                end
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= ssb_pkg::SSB_M_IDLE;
            cnt <= '0;
            bit_idx <= ssb_pkg::BIT_FIRST;
            addr <= ssb_pkg::BYTE_RST;
            data <= ssb_pkg::BYTE_RST;
            speed <= 1'b0;
            ack_ok <= 1'b0;
            sck_low <= 1'b0;
            apl_low <= 1'b0;
            sdd_low <= 1'b0;
            req_ready <= 1'b0;
            wr_done <= 1'b0;
            ack_fail <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            bit_idx <= next_bit_idx;
            addr <= next_addr;
            data <= next_data;
            speed <= next_speed;
            ack_ok <= next_ack_ok;
            sck_low <= next_sck_low;
            apl_low <= next_apl_low;
            sdd_low <= next_sdd_low;
            req_ready <= next_req_ready;
            wr_done <= next_wr_done;
            ack_fail <= next_ack_fail;
            irq_seen <= next_irq_seen;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Enable only while pulling low, so lines idle high on pull-ups
    assign bus.m_sck_o = 1'b0;
    assign bus.m_sck_oe = sck_low;
    assign bus.m_apl_o = 1'b0;
    assign bus.m_apl_oe = apl_low;
    assign bus.m_sdd_o = 1'b0;
    assign bus.m_sdd_oe = sdd_low;

endmodule

/* File: ssb_link_assertions.sv */
// Concurrent checks on the lines of one link that joins a host end and a device end.
// Assumes both ends are design modules and every line is open-drain with a pull-up.
module ssb_link_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Host drivers
    input wire logic m_sck_o,
    input wire logic m_sck_oe,
    input wire logic m_apl_o,
    input wire logic m_apl_oe,
    input wire logic m_sdd_o,
    input wire logic m_sdd_oe,
    // Device drivers
    input wire logic s_apl_o,
    input wire logic s_apl_oe,
    input wire logic s_sdd_o,
    input wire logic s_sdd_oe,
    // Resolved lines
    input wire logic bit_clk,
    input wire logic addr_phase_irq_line,
    input wire logic serial_data_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int H_FAST = ssb_pkg::HALF_HS_CYC;
    localparam int H_SLOW = ssb_pkg::HALF_LS_CYC;
    logic clk_q, apl_q, last_data, next_last_data;
    logic [4:0] bit_no, next_bit_no;
    logic [9:0] low_len, next_low_len;

    // ********************
    // Frame tracking
    // ********************
    // Bit number plus one, bumped on each clock fall; a new frame starts with the address line
    always_comb begin
        next_bit_no = bit_no;
        next_last_data = last_data;
        next_low_len = bit_clk ? 10'h000 : low_len + 10'h001;
        if (clk_q && !bit_clk) begin
            next_bit_no = (m_apl_oe && !apl_q) ? 5'h01 : bit_no + 5'h01;
        end
        if (!clk_q && bit_clk && bit_no == 5'h10) begin
            next_last_data = serial_data_line;
        end
    end

    // Registers only; reset leaves the clock seen as idle high
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clk_q <= 1'b1;
            apl_q <= 1'b0;
            bit_no <= 5'h00;
            last_data <= 1'b0;
            low_len <= 10'h000;
        end else begin
            clk_q <= bit_clk;
            apl_q <= m_apl_oe;
            bit_no <= next_bit_no;
            last_data <= next_last_data;
            low_len <= next_low_len;
        end
    end

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    a_open_drain_only: assert property (
        !m_sck_o && !m_apl_o && !m_sdd_o && !s_apl_o && !s_sdd_o)
        else $error("a line is driven high");
    a_addr_phase_low: assert property (
        $rose(bit_clk) && bit_no >= 5'h01 && bit_no <= 5'h08 |-> m_apl_oe && !addr_phase_irq_line)
        else $error("address line not low during address bit");
    a_data_phase_high: assert property (
        $rose(bit_clk) && bit_no >= 5'h09 |-> !m_apl_oe)
        else $error("host holds address line in data phase");
    a_host_releases_data: assert property (
        $rose(bit_clk) && bit_no >= 5'h11 |-> !m_sdd_oe)
        else $error("host still drives data line at acknowledge");
    a_ack_inverse: assert property (
        $rose(bit_clk) && bit_no == 5'h11 |-> serial_data_line != last_data)
        else $error("acknowledge is not the inverse of the last data bit");
    a_dev_releases_data: assert property (
        $rose(bit_clk) && bit_no == 5'h12 |-> serial_data_line && !s_sdd_oe)
        else $error("data line not high after acknowledge");
    a_low_half_len: assert property (
        $rose(bit_clk) |-> low_len == H_FAST || low_len == H_SLOW)
        else $error("clock low half has a wrong length");
    a_irq_release_fall: assert property (
        $fell(bit_clk) |-> ##6 !s_apl_oe)
        else $error("device holds address line after clock fall");
    a_dev_moves_low: assert property (
        $changed(s_sdd_oe) |-> !bit_clk)
        else $error("device changed data line while clock high");
    a_irq_only_idle: assert property (
        $rose(s_apl_oe) |-> bit_clk && !m_apl_oe && !m_sck_oe)
        else $error("device pulled address line outside idle");

    c_ack_bit: cover property ($rose(bit_clk) && bit_no == 5'h11);
    c_slow_half: cover property ($rose(bit_clk) && low_len == H_SLOW);
    c_irq_pull: cover property ($rose(s_apl_oe));
    c_irq_drop: cover property ($fell(s_apl_oe));
endmodule

/* File: ssb_link_if.sv */
// Bus carrier joining the host end and the device end.
// Assumes every line is open-drain with a pull-up: any party driving low wins.
interface ssb_link_if;

    // ************************************************************
    // Per-party drivers
    // ************************************************************
    logic m_sck_o;
    logic m_sck_oe;
    logic m_apl_o;
    logic m_apl_oe;
    logic m_sdd_o;
    logic m_sdd_oe;
    logic s_apl_o;
    logic s_apl_oe;
    logic s_sdd_o;
    logic s_sdd_oe;

    // ************************************************************
    // Resolved line levels
    // ************************************************************
    logic bit_clk;
    logic addr_phase_irq_line;
    logic serial_data_line;

    // Wired-AND with pull-up when nobody pulls low
    assign bit_clk = !(m_sck_oe && !m_sck_o);
    assign addr_phase_irq_line = !((m_apl_oe && !m_apl_o) || (s_apl_oe && !s_apl_o));
    assign serial_data_line = !((m_sdd_oe && !m_sdd_o) || (s_sdd_oe && !s_sdd_o));

    modport host (
        output m_sck_o, m_sck_oe, m_apl_o, m_apl_oe, m_sdd_o, m_sdd_oe,
        input addr_phase_irq_line, serial_data_line
    );

    modport device (
        output s_apl_o, s_apl_oe, s_sdd_o, s_sdd_oe,
        input bit_clk, addr_phase_irq_line, serial_data_line
    );

endinterface

/* File: ssb_pkg.sv */
// Shared constants and state types for both ends of the three-wire serial register bus.
// Assumes a single 40 MHz system clock on each end and open-drain lines with pull-ups.
package ssb_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned HALF_LS_NS = 15_000;   // Low-speed half-period, 15 us
    localparam int unsigned HALF_HS_NS = 500;      // High-speed half-period, 0.5 us
    // Least times, so round up to whole cycles
    localparam int unsigned HALF_LS_CYC = (HALF_LS_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned HALF_HS_CYC = (HALF_HS_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int HALF_W = 10;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 8;
    localparam logic [4:0] BIT_FIRST = 5'h00;
    localparam logic [4:0] BIT_DATA0 = 5'h08;
    localparam logic [4:0] BIT_ACK = 5'h10;
    localparam logic [4:0] BIT_END = 5'h11;
    localparam logic [2:0] CNT_LAST = 3'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ************************************************************
    // State types
    // ************************************************************
    typedef enum logic [1:0] {
        SSB_M_IDLE = 2'b00,
        SSB_M_LOW = 2'b01,
        SSB_M_HIGH = 2'b11,
        SSB_M_GAP = 2'b10
    } ssb_mst_state_t;

    typedef enum logic [2:0] {
        SSB_S_IDLE = 3'b000,
        SSB_S_ADDR = 3'b001,
        SSB_S_DATA = 3'b011,
        SSB_S_ACK = 3'b010,
        SSB_S_HOLD = 3'b110,
        SSB_S_FIN = 3'b100
    } ssb_slv_state_t;

endpackage
